// [design/ivs_pkg.sv]
// Purpose: shared constants and types for the interrupt vector and stacking block
// Assumes: 8-bit core, 16-bit addresses, one core clock
// Notes: vector addresses are low bytes of two-byte entries
package ivs_pkg;
   localparam int NSRC = 22;
   // vector addresses
   localparam logic [15:0] VEC_RESERVED_LO = 16'hFFC0;
   localparam logic [15:0] VEC_SERIAL = 16'hFFD6;
   localparam logic [15:0] VEC_SPI = 16'hFFD8;
   localparam logic [15:0] VEC_PA_EDGE = 16'hFFDA;
   localparam logic [15:0] VEC_PA_OVF = 16'hFFDC;
   localparam logic [15:0] VEC_TOF = 16'hFFDE;
   localparam logic [15:0] VEC_IC4OC5 = 16'hFFE0;
   localparam logic [15:0] VEC_OC4 = 16'hFFE2;
   localparam logic [15:0] VEC_IC3 = 16'hFFEA;
   localparam logic [15:0] VEC_RTI = 16'hFFF0;
   localparam logic [15:0] VEC_IRQ = 16'hFFF2;
   localparam logic [15:0] VEC_NMI = 16'hFFF4;
   localparam logic [15:0] VEC_SWI = 16'hFFF6;
   localparam logic [15:0] VEC_ILL = 16'hFFF8;
   localparam logic [15:0] VEC_WDOG = 16'hFFFA;
   localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
   localparam logic [15:0] VEC_RESET = 16'hFFFE;
   localparam logic [15:0] VEC_STEP = 16'h0002;
   // priority select reset value and reserved code
   localparam logic [3:0] PSEL_RESET = 4'h6;
   localparam logic [3:0] PSEL_RSVD = 4'h5;
   // stack frame: nine bytes, offsets below the entry stack pointer
   localparam logic [3:0] FRAME_BYTES = 4'h9;
   localparam logic [3:0] FRAME_LAST = 4'h8;
   // maskable request bundle, index is fixed priority order (0 highest)
   typedef struct packed {
      logic serial;      // 14
      logic spi;         // 13
      logic pa_edge;     // 12
      logic pa_ovf;      // 11
      logic tof;         // 10
      logic ic4oc5;      // 9
      logic oc4;         // 8
      logic oc3;         // 7
      logic oc2;         // 6
      logic oc1;         // 5
      logic ic3;         // 4
      logic ic2;         // 3
      logic ic1;         // 2
      logic rti;         // 1
      logic irq;         // 0
   } ivs_mask_req_t;
   // cpu register set pushed on entry
   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] iy;
      logic [15:0] ix;
      logic [7:0] acc_a;
      logic [7:0] acc_b;
      logic [7:0] condition_code_register;
   } ivs_regs_t;
   // condition code bit positions
   localparam int CCR_X = 6;
   localparam int CCR_I = 4;
   // serial sub-source bundle
   typedef struct packed {
      logic rx_full;
      logic overrun;
      logic tx_empty;
      logic tx_done;
      logic idle;
   } ivs_serial_t;
endpackage : ivs_pkg

// [design/ivs_serial_gate.sv]
// Purpose: serial unit source gating and receive-full auto clear
// Assumes: status and data read strobes are one-cycle pulses from the core
// Notes: receive-full is set by the receiver pulse, set wins over clear
`timescale 1ns/100ps
module ivs_serial_gate
   import ivs_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // events and enables
   input wire logic rx_full_set_in,
   input wire ivs_serial_t flags_in,
   input wire ivs_serial_t enables_in,
   input wire logic status_rd_in,
   input wire logic data_rd_in,
   // results
   output logic rx_full_out,
   output logic req_out
);
   logic rx_full_reg;
   logic armed_reg;
   ivs_serial_t eff;

   // status read while flag set arms the clear; data read completes it
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         armed_reg <= 1'b0;
      end else if (status_rd_in && rx_full_reg) begin
         armed_reg <= 1'b1;
      end else if (data_rd_in || !rx_full_reg) begin
         armed_reg <= 1'b0;
      end
   end

   // set wins over the auto clear so a new byte is never lost
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_full_reg <= 1'b0;
      end else if (rx_full_set_in) begin
         rx_full_reg <= 1'b1;
      end else if (armed_reg && data_rd_in) begin
         rx_full_reg <= 1'b0;
      end
   end

   // every sub-source gated by its own enable
   always_comb begin
      eff = flags_in;
      eff.rx_full = rx_full_reg;
   end
   assign req_out = |(eff & enables_in);
   assign rx_full_out = rx_full_reg;

   a_rx_auto_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      armed_reg && data_rd_in && !rx_full_set_in |=> !rx_full_reg)
      else $error("receive flag not cleared");
   a_rx_no_early: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      rx_full_reg && !armed_reg && !status_rd_in |=> rx_full_reg)
      else $error("receive flag cleared without status read");
   c_rx_clear: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      status_rd_in ##1 data_rd_in);
endmodule : ivs_serial_gate

// [design/ivs_prio_pick.sv]
// Purpose: fixed-order maskable priority with one promoted source
// Assumes: requests already gated by local enables
// Notes: reserved select code behaves as the external pin
`timescale 1ns/100ps
module ivs_prio_pick
   import ivs_pkg::*;
(
   // inputs
   input wire logic [14:0] req_in,
   input wire logic [3:0] psel_in,
   // result
   output logic any_out,
   output logic [15:0] vec_out
);
   logic [3:0] promo;
   logic [15:0] vtab [15];

   // select code to fixed-order index
   always_comb begin
      case (psel_in)
         4'h0: promo = 4'd10;
         4'h1: promo = 4'd11;
         4'h2: promo = 4'd12;
         4'h3: promo = 4'd13;
         4'h4: promo = 4'd14;
         4'h7: promo = 4'd1;
         4'h8: promo = 4'd2;
         4'h9: promo = 4'd3;
         4'hA: promo = 4'd4;
         4'hB: promo = 4'd5;
         4'hC: promo = 4'd6;
         4'hD: promo = 4'd7;
         4'hE: promo = 4'd8;
         4'hF: promo = 4'd9;
         default: promo = 4'd0;
      endcase
   end

   // vectors per fixed index; vectors ignore promotion
   genvar g;
   generate
      for (g = 0; g < 15; g++) begin : g_vec
         if (g == 0) begin : g_irq
            assign vtab[g] = VEC_IRQ;
         end else if (g == 1) begin : g_rti
            assign vtab[g] = VEC_RTI;
         end else if (g <= 4) begin : g_ic
            assign vtab[g] = 16'(VEC_RTI - VEC_STEP * 16'(g - 1));
         end else if (g <= 8) begin : g_oc
            assign vtab[g] = 16'(VEC_IC3 - VEC_STEP * 16'(g - 4));
         end else begin : g_low
            assign vtab[g] = 16'(VEC_IC4OC5 - VEC_STEP * 16'(g - 9));
         end
      end
   endgenerate

   // promoted source first, then lowest index
   always_comb begin
      vec_out = VEC_IRQ;
      for (int i = 14; i >= 0; i--) begin
         if (req_in[i]) begin
            vec_out = vtab[i];
         end
      end
      if (req_in[promo]) begin
         vec_out = vtab[promo];
      end
      any_out = |req_in;
   end
endmodule : ivs_prio_pick

// [design/ivs_core.sv]
// Purpose: interrupt recognition, vector choice and register stacking
// Assumes: core signals instruction boundaries and hands its registers over
// Notes: one byte written or read per clock on the stack port
`timescale 1ns/100ps
module ivs_core
   import ivs_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // peripheral flags and local enables, same clock domain
   input wire ivs_mask_req_t flag_in,
   input wire ivs_mask_req_t enable_in,
   input wire ivs_serial_t serial_flag_in,
   input wire ivs_serial_t serial_enable_in,
   input wire logic rx_full_set_in,
   input wire logic serial_status_rd_in,
   input wire logic serial_data_rd_in,
   // asynchronous pins, active low
   input wire logic irq_n_in,
   input wire logic nonmaskable_pin_request_n_in,
   // system faults and configuration
   input wire logic watchdog_fail_in,
   input wire logic watchdog_disable_in,
   input wire logic clock_fail_in,
   input wire logic clock_monitor_enable_in,
   input wire logic swi_in,
   input wire logic illegal_in,
   // core sequencer side
   input wire logic instr_done_in,
   input wire logic rti_in,
   input wire ivs_regs_t regs_in,
   input wire logic [15:0] sp_in,
   input wire logic [7:0] pull_data_in,
   input wire logic psel_wr_in,
   input wire logic [3:0] psel_data_in,
   // outputs to the core
   output logic [15:0] vector_out,
   output logic vector_valid_out,
   output logic [15:0] stack_addr_out,
   output logic [7:0] stack_data_out,
   output logic stack_wr_out,
   output logic stack_rd_out,
   output logic [7:0] ccr_out,
   output logic resume_out,
   output logic rx_full_out,
   output logic [3:0] psel_out
);
   typedef enum logic [4:0] {
      S_RUN = 5'b00001,
      S_PUSH = 5'b00010,
      S_VEC = 5'b00100,
      S_PULL = 5'b01000,
      S_DONE = 5'b10000
   } ivs_state_t;

   ivs_state_t state_reg;
   logic irq_s1_reg, irq_s2_reg, nmi_s1_reg, nmi_s2_reg;
   logic [3:0] idx_reg;
   logic [15:0] sp_reg;
   logic [71:0] frame_reg;
   logic [7:0] ccr_reg;
   logic [3:0] psel_reg;
   logic nmi_taken_reg;
   logic [15:0] vec_reg;
   logic [15:0] mvec;
   logic many, ser_req, i_ok, x_ok, nmi_pend, any_pend;
   logic [14:0] gated;
   logic [15:0] pick_vec;
   logic [7:0] pull_ccr;

   // two-stage synchronisers for the pins
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_s1_reg <= 1'b1;
         irq_s2_reg <= 1'b1;
         nmi_s1_reg <= 1'b1;
         nmi_s2_reg <= 1'b1;
      end else begin
         irq_s1_reg <= irq_n_in;
         irq_s2_reg <= irq_s1_reg;
         nmi_s1_reg <= nonmaskable_pin_request_n_in;
         nmi_s2_reg <= nmi_s1_reg;
      end
   end

   ivs_serial_gate u_serial (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .rx_full_set_in(rx_full_set_in),
      .flags_in(serial_flag_in),
      .enables_in(serial_enable_in),
      .status_rd_in(serial_status_rd_in),
      .data_rd_in(serial_data_rd_in),
      .rx_full_out(rx_full_out),
      .req_out(ser_req)
   );

   // local gating; pin source has no local enable; requests track flags
   always_comb begin
      gated = 15'(flag_in & enable_in);
      gated[0] = !irq_s2_reg;
      gated[14] = ser_req;
   end

   ivs_prio_pick u_pick (
      .req_in(gated),
      .psel_in(psel_reg),
      .any_out(many),
      .vec_out(pick_vec)
   );

   // global masks and fixed non-maskable order
   always_comb begin
      i_ok = !ccr_reg[CCR_I] && many;
      x_ok = !ccr_reg[CCR_X] && !nmi_s2_reg;
      nmi_pend = 1'b0;
      mvec = VEC_RESET;
      any_pend = 1'b1;
      if (clock_fail_in && clock_monitor_enable_in) begin
         mvec = VEC_CLKMON;
      end else if (watchdog_fail_in && !watchdog_disable_in) begin
         mvec = VEC_WDOG;
      end else if (x_ok) begin
         mvec = VEC_NMI;
         nmi_pend = 1'b1;
      end else if (illegal_in) begin
         mvec = VEC_ILL;
      end else if (swi_in) begin
         mvec = VEC_SWI;
      end else if (i_ok) begin
         mvec = pick_vec;
      end else begin
         any_pend = 1'b0;
      end
   end

   // priority select; writable only while the global mask is set
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         psel_reg <= PSEL_RESET;
      end else if (psel_wr_in && ccr_reg[CCR_I]) begin
         psel_reg <= psel_data_in;
      end
   end

   // service sequencer
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= S_RUN;
         idx_reg <= 4'h0;
      end else begin
         case (state_reg)
            S_RUN: begin
               if (instr_done_in && any_pend) begin
                  state_reg <= S_PUSH;
                  idx_reg <= 4'h0;
               end else if (rti_in) begin
                  state_reg <= S_PULL;
                  idx_reg <= 4'h0;
               end
            end
            S_PUSH: begin
               idx_reg <= idx_reg + 4'h1;
               if (idx_reg == FRAME_LAST) begin
                  state_reg <= S_VEC;
               end
            end
            S_PULL: begin
               idx_reg <= idx_reg + 4'h1;
               if (idx_reg == FRAME_LAST) begin
                  state_reg <= S_DONE;
               end
            end
            S_VEC, S_DONE: state_reg <= S_RUN;
            default: state_reg <= S_RUN;
         endcase
      end
   end

   // capture frame and vector at entry; a late source cannot switch vectors
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         frame_reg <= '0;
         sp_reg <= 16'h0000;
         vec_reg <= VEC_RESET;
         nmi_taken_reg <= 1'b0;
      end else if (state_reg == S_RUN && instr_done_in && any_pend) begin
         // byte order: pc low, pc high, y low, y high, x low, x high, a, b, ccr
         frame_reg <= {regs_in.condition_code_register, regs_in.acc_b, regs_in.acc_a,
                       regs_in.ix[15:8], regs_in.ix[7:0], regs_in.iy[15:8],
                       regs_in.iy[7:0], regs_in.pc[15:8], regs_in.pc[7:0]};
         sp_reg <= sp_in;
         vec_reg <= mvec;
         nmi_taken_reg <= nmi_pend;
      end else if (state_reg == S_RUN && rti_in) begin
         sp_reg <= sp_in;
      end
   end

   // registered read port: the condition code byte stands while the pull index is one
   assign pull_ccr = pull_data_in;

   // condition code mask bits
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ccr_reg <= 8'h50;
      end else if (state_reg == S_PUSH && idx_reg == FRAME_LAST) begin
         ccr_reg[CCR_I] <= 1'b1;
         if (nmi_taken_reg) begin
            ccr_reg[CCR_X] <= 1'b1;
         end
      end else if (state_reg == S_PULL && idx_reg == 4'h1) begin
         ccr_reg <= pull_ccr;
      end else if (state_reg == S_RUN && !rti_in) begin
         ccr_reg <= {regs_in.condition_code_register[7], ccr_reg[CCR_X] & regs_in.condition_code_register[CCR_X],
                     regs_in.condition_code_register[5:0]};
      end
   end

   // stack bus outputs, registered
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stack_addr_out <= 16'h0000;
         stack_data_out <= 8'h00;
         stack_wr_out <= 1'b0;
         stack_rd_out <= 1'b0;
         vector_out <= VEC_RESET;
         vector_valid_out <= 1'b0;
         resume_out <= 1'b0;
      end else begin
         stack_wr_out <= (state_reg == S_PUSH);
         stack_rd_out <= (state_reg == S_PULL);
         stack_addr_out <= (state_reg == S_PULL) ?
            16'(sp_reg + 16'h0001 + 16'(idx_reg)) : 16'(sp_reg - 16'(idx_reg));
         stack_data_out <= (state_reg == S_PUSH) ? frame_reg[8*idx_reg +: 8] : 8'h00; // no read past frame
         vector_valid_out <= (state_reg == S_VEC);
         vector_out <= vec_reg;
         resume_out <= (state_reg == S_DONE);
      end
   end

   assign ccr_out = ccr_reg;
   assign psel_out = psel_reg;

   a_entry_boundary: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(state_reg == S_PUSH) |-> $past(instr_done_in) && $past(state_reg == S_RUN))
      else $error("service started mid-instruction");
   a_push_length: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(state_reg == S_PUSH) |-> (state_reg == S_PUSH) [*8] ##1 state_reg == S_PUSH
      ##1 state_reg == S_VEC)
      else $error("stack frame not nine bytes");
   a_mask_after: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      state_reg == S_VEC |-> ccr_reg[CCR_I])
      else $error("global mask not set after stacking");
   a_psel_reset: assert property (@(posedge ref_clk_in)
      $rose(rst_n_in) |-> psel_reg == PSEL_RESET)
      else $error("priority select reset wrong");
   a_mask_block: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      ccr_reg[CCR_I] && !x_ok && !swi_in && !illegal_in && !watchdog_fail_in
      && !clock_fail_in |-> !any_pend)
      else $error("masked request recognised");
   a_pull_resume: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(state_reg == S_PULL) |-> ##9 state_reg == S_DONE ##1 resume_out)
      else $error("return sequence wrong");
   a_swi_vector: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      swi_in && !illegal_in && !x_ok && !watchdog_fail_in && !clock_fail_in
      |-> mvec == VEC_SWI)
      else $error("software interrupt vector wrong");
   a_nmi_xmask: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      state_reg == S_VEC && nmi_taken_reg |-> ccr_reg[CCR_X])
      else $error("pin mask not set");
   c_maskable: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      state_reg == S_VEC && !nmi_taken_reg);
   c_nmi: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      state_reg == S_VEC && nmi_taken_reg);
   c_return: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) resume_out);
endmodule : ivs_core

// [tb/ivs_stack_model.sv]
// Purpose: stack memory on the core side of the stack port
// Assumes: one byte written or read per clock, read data combinational
// Notes: released read data shows the inverted last byte, never a stale one
`timescale 1ns/100ps
module ivs_stack_model (
   // clock
   input wire logic ref_clk_in,
   // stack port from the block
   input wire logic [15:0] addr_in,
   input wire logic [7:0] data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   // pulled byte back to the block
   output logic [7:0] data_out
);
   logic [7:0] mem [0:255];
   logic [7:0] last_reg;
   // pushes land at the edge; only the low page is modelled
   always_ff @(posedge ref_clk_in) begin
      if (wr_in) begin
         mem[addr_in[7:0]] <= data_in;
      end
      if (rd_in) begin
         last_reg <= mem[addr_in[7:0]];
      end
   end
   // bus released between pulls so a late sample is caught
   assign data_out = rd_in ? mem[addr_in[7:0]] : ~last_reg;
endmodule : ivs_stack_model

// [tb/testbench.sv]
// Purpose: self-checking bench for the interrupt vector and stacking block
// Assumes: core sequencer played by tasks, stack memory by the model
// Notes: frames pushed at 00f0 and pulled from 00e7
`timescale 1ns/100ps
module testbench;
   import ivs_pkg::*;
   logic ref_clk_in, rst_n_in, rx_full_set_in, serial_status_rd_in, serial_data_rd_in;
   logic irq_n_in, nonmaskable_pin_request_n_in, watchdog_fail_in, watchdog_disable_in;
   logic clock_fail_in, clock_monitor_enable_in, swi_in, illegal_in, instr_done_in, rti_in;
   logic psel_wr_in, vector_valid_out, stack_wr_out, stack_rd_out, resume_out, rx_full_out;
   ivs_mask_req_t flag_in, enable_in;
   ivs_serial_t serial_flag_in, serial_enable_in;
   ivs_regs_t regs_in;
   logic [15:0] sp_in, vector_out, stack_addr_out;
   logic [7:0] pull_data_in, stack_data_out, ccr_out;
   logic [3:0] psel_data_in, psel_out;
   logic [7:0] nserv = 8'h00;
   int fail_count = 0;
   int cmp_count = 0;
   ivs_core i_ivs_core (.ref_clk_in, .rst_n_in, .flag_in, .enable_in, .serial_flag_in,
      .serial_enable_in, .rx_full_set_in, .serial_status_rd_in, .serial_data_rd_in,
      .irq_n_in, .nonmaskable_pin_request_n_in, .watchdog_fail_in, .watchdog_disable_in,
      .clock_fail_in, .clock_monitor_enable_in, .swi_in, .illegal_in, .instr_done_in,
      .rti_in, .regs_in, .sp_in, .pull_data_in, .psel_wr_in, .psel_data_in, .vector_out,
      .vector_valid_out, .stack_addr_out, .stack_data_out, .stack_wr_out, .stack_rd_out,
      .ccr_out, .resume_out, .rx_full_out, .psel_out);
   ivs_stack_model i_ivs_stack_model (.ref_clk_in, .addr_in(stack_addr_out),
      .data_in(stack_data_out), .wr_in(stack_wr_out), .rd_in(stack_rd_out),
      .data_out(pull_data_in));
   // 20 MHz core clock
   initial begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask : cyc
   // request pending but nothing may be pushed or vectored
   task automatic no_serve(input logic pulse);
      logic seen;
      seen = 1'b0;
      @(posedge ref_clk_in);
      instr_done_in <= pulse;
      @(posedge ref_clk_in);
      instr_done_in <= 1'b0;
      repeat (14) begin
         @(negedge ref_clk_in);
         seen = seen | stack_wr_out | vector_valid_out;
      end
      chk(16'(seen), 16'h0000);
      @(posedge ref_clk_in);
   endtask : no_serve
   // one service: fresh return address each time so a stale frame cannot pass
   task automatic serve(input logic [15:0] vec, input logic [7:0] condition_code_register);
      logic [71:0] frame;
      int n;
      nserv++;
      frame = {8'h00, 8'hf0, 8'hde, 8'h9a, 8'hbc, 8'h56, 8'h78, 8'h12, nserv};
      @(posedge ref_clk_in);
      regs_in <= {8'h12, nserv, 16'h5678, 16'h9abc, 8'hde, 8'hf0, 8'h00};
      sp_in <= 16'h00f0;
      instr_done_in <= 1'b1;
      @(posedge ref_clk_in);
      instr_done_in <= 1'b0;
      n = 0;
      @(negedge ref_clk_in);
      while (vector_valid_out !== 1'b1 && n < 30) begin
         @(negedge ref_clk_in);
         n++;
      end
      chk(vector_out, vec);
      chk(16'(n), 16'h000a);
      chk(16'(ccr_out), 16'(condition_code_register));
      for (int i = 0; i < 9; i++) begin
         chk(16'(i_ivs_stack_model.mem[8'hf0 - 8'(i)]), 16'(frame[8*i +: 8]));
      end
      @(posedge ref_clk_in);
   endtask : serve
   // return: condition codes come back clear as they were pushed
   task automatic ret;
      int n;
      @(posedge ref_clk_in);
      sp_in <= 16'h00e7;
      rti_in <= 1'b1;
      @(posedge ref_clk_in);
      rti_in <= 1'b0;
      n = 0;
      @(negedge ref_clk_in);
      while (resume_out !== 1'b1 && n < 30) begin
         @(negedge ref_clk_in);
         n++;
      end
      chk(16'(n), 16'(10));
      chk(16'(ccr_out), 16'h0000);
      @(posedge ref_clk_in);
   endtask : ret
   task automatic print_verdict;
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict
   // hang guard, well beyond the roughly 1100 cycles of the sequence
   initial begin
      repeat (6000) @(posedge ref_clk_in);
      fail_count++;
      print_verdict();
   end
   // main sequence
   initial begin
      {rx_full_set_in, serial_status_rd_in, serial_data_rd_in, watchdog_fail_in} = '0;
      {watchdog_disable_in, clock_fail_in, clock_monitor_enable_in, swi_in} = '0;
      {illegal_in, instr_done_in, rti_in, psel_wr_in, psel_data_in} = '0;
      {flag_in, enable_in, serial_flag_in, serial_enable_in, regs_in, sp_in} = '0;
      // core condition codes out of reset: both masks set, mirrored by the block
      regs_in.condition_code_register = 8'h50;
      {irq_n_in, nonmaskable_pin_request_n_in} = 2'b11;
      rst_n_in = 1'b0;
      cyc(3);
      rst_n_in <= 1'b1;
      cyc(3);
      chk(vector_out, VEC_RESET);
      chk(16'(ccr_out), 16'h0050);
      chk(16'(psel_out), 16'(PSEL_RESET));
      flag_in <= ivs_mask_req_t'(15'h0400);
      enable_in <= ivs_mask_req_t'(15'h0400);
      nonmaskable_pin_request_n_in <= 1'b0;
      cyc(3);
      no_serve(1'b1);
      {flag_in, enable_in} <= '0;
      nonmaskable_pin_request_n_in <= 1'b1;
      swi_in <= 1'b1;
      cyc(3);
      serve(VEC_SWI, 8'h10);
      swi_in <= 1'b0;
      ret();
      for (int i = 1; i < 14; i++) begin
         flag_in <= ivs_mask_req_t'(15'(1) << i);
         no_serve(1'b1);
         enable_in <= ivs_mask_req_t'(15'(1) << i);
         no_serve(1'b0);
         serve(VEC_RTI - 16'(2 * (i - 1)), 8'h10);
         {flag_in, enable_in} <= '0;
         ret();
      end
      irq_n_in <= 1'b0;
      cyc(3);
      serve(VEC_IRQ, 8'h10);
      irq_n_in <= 1'b1;
      cyc(3);
      ret();
      serial_flag_in <= ivs_serial_t'(5'h04);
      serial_enable_in <= ivs_serial_t'(5'h04);
      serve(VEC_SERIAL, 8'h10);
      serial_flag_in <= '0;
      ret();
      flag_in <= ivs_mask_req_t'(15'h0404);
      enable_in <= ivs_mask_req_t'(15'h0404);
      serve(16'hffee, 8'h10);
      // core masks first: the select only takes writes while the global mask is set
      regs_in.condition_code_register <= 8'h10;
      cyc(1);
      psel_wr_in <= 1'b1;
      cyc(1);
      psel_wr_in <= 1'b0;
      regs_in.condition_code_register <= 8'h00;
      ret();
      chk(16'(psel_out), 16'h0000);
      serve(VEC_TOF, 8'h10);
      ret();
      psel_wr_in <= 1'b1;
      psel_data_in <= 4'h6;
      cyc(1);
      psel_wr_in <= 1'b0;
      cyc(2);
      chk(16'(psel_out), 16'h0000);
      {flag_in, enable_in} <= '0;
      illegal_in <= 1'b1;
      swi_in <= 1'b1;
      serve(VEC_ILL, 8'h10);
      illegal_in <= 1'b0;
      ret();
      serve(VEC_SWI, 8'h10);
      swi_in <= 1'b0;
      ret();
      watchdog_fail_in <= 1'b1;
      watchdog_disable_in <= 1'b1;
      no_serve(1'b1);
      watchdog_disable_in <= 1'b0;
      serve(VEC_WDOG, 8'h10);
      watchdog_fail_in <= 1'b0;
      ret();
      clock_fail_in <= 1'b1;
      clock_monitor_enable_in <= 1'b1;
      serve(VEC_CLKMON, 8'h10);
      clock_fail_in <= 1'b0;
      ret();
      nonmaskable_pin_request_n_in <= 1'b0;
      cyc(3);
      serve(VEC_NMI, 8'h50);
      nonmaskable_pin_request_n_in <= 1'b1;
      ret();
      // receive-full: data read alone must not clear it
      rx_full_set_in <= 1'b1;
      cyc(1);
      rx_full_set_in <= 1'b0;
      serial_data_rd_in <= 1'b1;
      cyc(1);
      serial_data_rd_in <= 1'b0;
      cyc(2);
      chk(16'(rx_full_out), 16'h0001);
      serial_status_rd_in <= 1'b1;
      cyc(1);
      serial_status_rd_in <= 1'b0;
      serial_data_rd_in <= 1'b1;
      cyc(1);
      serial_data_rd_in <= 1'b0;
      cyc(2);
      chk(16'(rx_full_out), 16'h0000);
      print_verdict();
   end
endmodule : testbench
